// ---- rtl/ddpl_palette_lut.sv ----
// Dual palette lookup with AHB-Lite register access and pixel translation
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ddpl_palette_lut
  import ddpl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pixel stream in
  input  wire logic [15:0] pixelIn,
  input  wire logic        pixelValid,
  output logic             pixelReady,
  // Translated colors out
  output ddpl_rgb_t        panelColor,
  output ddpl_rgb_t        crtColor,
  output logic             colorValid
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Select one component of an entry
  function automatic logic [3:0] ddpl_pick(input ddpl_rgb_t e, input ddpl_sel_t s);
    logic [3:0] v;
    v = e.blue;
    if (s == SEL_RED) begin
      v = e.red;
    end else if (s == SEL_GREEN) begin
      v = e.green;
    end
    return v;
  endfunction : ddpl_pick

  // Replace one component of an entry
  function automatic ddpl_rgb_t ddpl_put(input ddpl_rgb_t e, input ddpl_sel_t s,
                                         input logic [3:0] v);
    ddpl_rgb_t r;
    r = e;
    if (s == SEL_RED) begin
      r.red = v;
    end else if (s == SEL_GREEN) begin
      r.green = v;
    end else begin
      r.blue = v;
    end
    return r;
  endfunction : ddpl_put

  // Panel shading: monochrome repeats green on all primaries
  function automatic ddpl_rgb_t ddpl_panel_shade(input ddpl_rgb_t e, input logic color);
    ddpl_rgb_t r;
    r = e;
    if (!color) begin
      r = '{red: e.green, green: e.green, blue: e.green};
    end
    return r;
  endfunction : ddpl_panel_shade

  ////////////////////////////////////////////////////////////////////////////
  // Storage and control state

  ddpl_rgb_t       panelLut [ENTRY_COUNT];
  ddpl_rgb_t       crtLut   [ENTRY_COUNT];
  ddpl_mode_t      mode_q;
  logic [7:0]      index_q;
  ddpl_sel_t       sel_q;
  logic [7:0]      panelCfg_q;
  ddpl_depth_t     depth_q;
  logic            dphValid_q;
  logic            dphWrite_q;
  logic [11:0]     dphAddr_q;
  ddpl_pix_state_t pixState_q;
  logic [3:0]      lowNibble_q;
  ddpl_rgb_t       panelColor_q;
  ddpl_rgb_t       crtColor_q;
  logic            colorValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decoding

  // Address phase accepted when selected, bus ready and transfer active
  logic addrPhase;
  logic hitCfg;
  logic hitMode;
  logic hitIndex;
  logic hitData;
  logic hitDepth;
  logic wrCfg;
  logic wrMode;
  logic wrIndex;
  logic wrDepth;
  logic dataAccess;
  logic dataWrite;
  assign addrPhase  = hsel && hready && htrans[1];
  assign hitCfg     = dphValid_q && (dphAddr_q == ADDR_PANEL_CFG);
  assign hitMode    = dphValid_q && (dphAddr_q == ADDR_MODE);
  assign hitIndex   = dphValid_q && (dphAddr_q == ADDR_INDEX);
  assign hitData    = dphValid_q && (dphAddr_q == ADDR_DATA);
  assign hitDepth   = dphValid_q && (dphAddr_q == ADDR_DEPTH);
  assign wrCfg      = hitCfg && dphWrite_q;
  assign wrMode     = hitMode && dphWrite_q;
  assign wrIndex    = hitIndex && dphWrite_q;
  assign wrDepth    = hitDepth && dphWrite_q;
  assign dataAccess = hitData;
  assign dataWrite  = hitData && dphWrite_q;

  // Palette routing by access mode
  logic readCrt;
  logic panelWe;
  logic crtWe;
  assign readCrt = (mode_q == MODE_CRT_ONLY) || (mode_q == MODE_READ_CRT_WRITE_BOTH);
  assign panelWe = dataWrite && (mode_q != MODE_CRT_ONLY);
  assign crtWe   = dataWrite && (mode_q != MODE_PANEL_ONLY);

  // Selector and index stepping on data accesses
  logic      lastComp;
  ddpl_sel_t selNext;
  assign lastComp = (sel_q == SEL_BLUE);
  assign selNext  = (sel_q == SEL_RED) ? SEL_GREEN : (lastComp ? SEL_RED : SEL_BLUE);

  // Component at the current entry for reads
  ddpl_rgb_t  readEntry;
  logic [3:0] readComp;
  assign readEntry = readCrt ? crtLut[index_q] : panelLut[index_q];
  assign readComp  = ddpl_pick(readEntry, sel_q);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite answer: zero wait states, always OKAY, unmapped reads zero

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata = (hitCfg   && !dphWrite_q) ? {24'h000000, panelCfg_q} :
                  (hitMode  && !dphWrite_q) ? {30'h00000000, mode_q} :
                  (hitIndex && !dphWrite_q) ? {24'h000000, index_q} :
                  (hitData  && !dphWrite_q) ? {24'h000000, readComp, 4'h0} :
                  (hitDepth && !dphWrite_q) ? {30'h00000000, depth_q} :
                  32'h00000000;

  // Address phase capture
  // The slave never stalls, so the capture follows every ready cycle. An idle
  // or unselected cycle clears the valid bit, and a stale address can never
  // strike a register again in a later data phase.
  always_ff @(posedge clk) begin
    if (reset) begin
      dphValid_q <= 1'b0;
      dphWrite_q <= 1'b0;
      dphAddr_q  <= 12'h000;
    end else if (hready) begin
      dphValid_q <= addrPhase;
      dphWrite_q <= hwrite;
      dphAddr_q  <= haddr[11:0];
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q     <= ddpl_mode_t'(RST_MODE);
      panelCfg_q <= RST_PANEL_CFG;
      depth_q    <= ddpl_depth_t'(RST_DEPTH);
    end else begin
      if (wrMode) begin
        mode_q <= ddpl_mode_t'(hwdata[MODE_LSB +: 2]);
      end
      if (wrCfg) begin
        panelCfg_q <= hwdata[7:0];
      end
      if (wrDepth) begin
        depth_q <= ddpl_depth_t'(hwdata[DEPTH_LSB +: 2]);
      end
    end
  end

  // Entry index and component selector
  // An index write wins over a data access in the same data phase. Both cannot
  // occur together, since both decode the one captured address, so the order only fixes the priority.
  // Reads step the selector just as writes do. Software that reads an entry back
  // must therefore reload the index before it writes the same entry again.
  always_ff @(posedge clk) begin
    if (reset) begin
      index_q <= RST_INDEX;
      sel_q   <= SEL_RED;
    end else if (wrIndex) begin
      index_q <= hwdata[7:0];
      sel_q   <= SEL_RED;
    end else if (dataAccess) begin
      sel_q <= selNext;
      if (lastComp) begin
        index_q <= 8'(index_q + 8'h01);
      end
    end
  end

  // Palette writes, one component at a time
  // The arrays have no reset, and their contents are unknown until software
  // loads them. Each write replaces only the component that the selector
  // points at, and the other two components of the entry are kept.
  always_ff @(posedge clk) begin
    if (panelWe) begin
      panelLut[index_q] <= ddpl_put(panelLut[index_q], sel_q, hwdata[DATA_LSB +: 4]);
    end
    if (crtWe) begin
      crtLut[index_q] <= ddpl_put(crtLut[index_q], sel_q, hwdata[DATA_LSB +: 4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel translation

  // Panel color or monochrome select
  logic colorPanel;
  assign colorPanel = panelCfg_q[COLOR_SEL_BIT];

  // Depth classification
  logic depth4;
  logic bypass;
  assign depth4 = (depth_q == DEPTH_4BPP);
  assign bypass = (depth_q == DEPTH_15BPP) || (depth_q == DEPTH_16BPP);

  // Nibble sequencing: upper nibble first, then the latched lower nibble
  logic pixTake;
  logic pixStep;
  assign pixelReady = (pixState_q == PIX_UPPER);
  assign pixTake    = pixelValid && pixelReady;
  assign pixStep    = pixTake || (pixState_q == PIX_LOWER);

  // Palette index for the pixel now being translated
  logic [7:0] lutIndex;
  assign lutIndex = (pixState_q == PIX_LOWER) ? {4'h0, lowNibble_q} :
                    depth4 ? {4'h0, pixelIn[7:4]} :
                    pixelIn[7:0];

  // Direct color for bypass depths, four top bits of each primary kept
  // 15 bpp packs five bits per primary below a reserved top bit. 16 bpp gives
  // green six bits. In both cases the low bits are dropped, because each
  // output primary is only four bits wide.
  ddpl_rgb_t direct15;
  ddpl_rgb_t direct16;
  ddpl_rgb_t directColor;
  assign direct15.red    = pixelIn[14:11];
  assign direct15.green  = pixelIn[9:6];
  assign direct15.blue   = pixelIn[4:1];
  assign direct16.red    = pixelIn[15:12];
  assign direct16.green  = pixelIn[10:7];
  assign direct16.blue   = pixelIn[4:1];
  assign directColor     = (depth_q == DEPTH_15BPP) ? direct15 : direct16;

  // Looked-up or direct colors for both outputs
  ddpl_rgb_t panelRaw;
  ddpl_rgb_t crtRaw;
  assign panelRaw = bypass ? directColor : panelLut[lutIndex];
  assign crtRaw   = bypass ? directColor : crtLut[lutIndex];

  // Sequencer state
  // At 4 bpp the lower nibble is latched when its byte is taken, and it is
  // translated in the following cycle. Ready is low in that cycle, so the
  // source holds its next word. The other depths never leave the upper state.
  always_ff @(posedge clk) begin
    if (reset) begin
      pixState_q  <= PIX_UPPER;
      lowNibble_q <= 4'h0;
    end else begin
      case (pixState_q)
        PIX_UPPER: begin
          if (pixTake && depth4) begin
            pixState_q  <= PIX_LOWER;
            lowNibble_q <= pixelIn[3:0];
          end
        end
        PIX_LOWER: begin
          pixState_q <= PIX_UPPER;
        end
        default: begin
          pixState_q <= PIX_UPPER;
        end
      endcase
    end
  end

  // Output registers
  // Colors are held between valid pulses, so a slow consumer can sample them
  // late. A palette write lands in the lookup at the clock edge, and a pixel
  // that is taken at the edge of the write still sees the old entry.
  always_ff @(posedge clk) begin
    if (reset) begin
      panelColor_q <= '0;
      crtColor_q   <= '0;
      colorValid_q <= 1'b0;
    end else begin
      colorValid_q <= pixStep;
      if (pixStep) begin
        panelColor_q <= ddpl_panel_shade(panelRaw, colorPanel);
        crtColor_q   <= crtRaw;
      end
    end
  end

  // Registered colors and valid pulse drive the ports directly
  assign panelColor = panelColor_q;
  assign crtColor   = crtColor_q;
  assign colorValid = colorValid_q;

endmodule : ddpl_palette_lut

// ---- rtl/ddpl_pkg.sv ----
// Constants, field layouts and carrier types for the dual display palette lookup
package ddpl_pkg;

  // Palette geometry
  localparam int unsigned ENTRY_COUNT = 256;
  localparam int unsigned COMP_W      = 4;
  localparam int unsigned INDEX_W     = 8;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_PANEL_CFG = 12'h030;
  localparam logic [11:0] IDX_MODE      = 12'h1E0;
  localparam logic [11:0] IDX_INDEX     = 12'h1E2;
  localparam logic [11:0] IDX_DATA      = 12'h1E4;
  localparam logic [11:0] IDX_DEPTH     = 12'h1E6;
  localparam logic [11:0] ADDR_PANEL_CFG = IDX_PANEL_CFG << 2;
  localparam logic [11:0] ADDR_MODE      = IDX_MODE << 2;
  localparam logic [11:0] ADDR_INDEX     = IDX_INDEX << 2;
  localparam logic [11:0] ADDR_DATA      = IDX_DATA << 2;
  localparam logic [11:0] ADDR_DEPTH     = IDX_DEPTH << 2;

  // Field positions
  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned COLOR_SEL_BIT = 2;
  localparam int unsigned DATA_LSB     = 4;
  localparam int unsigned DEPTH_LSB    = 0;

  // Values after reset
  localparam logic [1:0] RST_MODE      = 2'h0;
  localparam logic [7:0] RST_INDEX     = 8'h00;
  localparam logic [7:0] RST_PANEL_CFG = 8'h00;
  localparam logic [1:0] RST_DEPTH     = 2'h1;

  // One palette entry, four bits per primary
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } ddpl_rgb_t;

  // Component selector of the data register
  typedef enum logic [1:0] {
    SEL_RED   = 2'b00,
    SEL_GREEN = 2'b01,
    SEL_BLUE  = 2'b10
  } ddpl_sel_t;

  // Which palette(s) host accesses reach
  typedef enum logic [1:0] {
    MODE_READ_PANEL_WRITE_BOTH = 2'b00,
    MODE_PANEL_ONLY            = 2'b01,
    MODE_CRT_ONLY              = 2'b10,
    MODE_READ_CRT_WRITE_BOTH   = 2'b11
  } ddpl_mode_t;

  // Color depth of the incoming pixels
  typedef enum logic [1:0] {
    DEPTH_4BPP  = 2'b00,
    DEPTH_8BPP  = 2'b01,
    DEPTH_15BPP = 2'b10,
    DEPTH_16BPP = 2'b11
  } ddpl_depth_t;

  // Nibble sequencer for 4 bpp bytes
  typedef enum logic {
    PIX_UPPER = 1'b0,
    PIX_LOWER = 1'b1
  } ddpl_pix_state_t;

endpackage : ddpl_pkg

// ---- sim/ddpl_palette_lut_properties.sv ----
// Port checker for the dual palette lookup
`timescale 1ns/1ps
module ddpl_lut_checker
  import ddpl_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pixel path
  input wire logic        pixelValid,
  input wire logic        pixelReady,
  input wire ddpl_rgb_t   panelColor,
  input wire ddpl_rgb_t   crtColor,
  input wire logic        colorValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Read data phases, one cycle after the address phase
  logic rdPh_q;
  logic rdDat_q;
  always_ff @(posedge clk) begin
    rdPh_q  <= !reset && hsel && hready && htrans[1] && !hwrite;
    rdDat_q <= !reset && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == ADDR_DATA;
  end

  // Bus answers
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_upper_zero: assert property (rdPh_q |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_data_low: assert property (rdDat_q |-> hrdata[3:0] == 4'h0)
    else $error("component low nibble set");
  a_idle_quiet: assert property (!rdPh_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  // Pixel path
  a_pixel_answer: assert property (pixelValid && pixelReady |=> colorValid)
    else $error("taken pixel gave no color");
  a_nibble_pair: assert property ($fell(pixelReady) |-> colorValid ##1 (colorValid && pixelReady))
    else $error("second nibble not emitted");
  a_ready_wait: assert property (pixelValid && !pixelReady |=> pixelReady)
    else $error("stall longer than one cycle");
  a_no_spurious: assert property (colorValid |-> $past(pixelValid && pixelReady) || !$past(pixelReady))
    else $error("color without a pixel");
  a_colors_hold: assert property (!colorValid |-> $stable(panelColor) && $stable(crtColor))
    else $error("colors changed without valid");

  // Main scenarios
  c_pixel: cover property (pixelValid && pixelReady);
  c_nibble: cover property ($fell(pixelReady));
  c_data_read: cover property (rdDat_q);
endmodule : ddpl_lut_checker

bind ddpl_palette_lut ddpl_lut_checker ddpl_lut_checker_inst (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pixelValid(pixelValid), .pixelReady(pixelReady), .panelColor(panelColor),
  .crtColor(crtColor), .colorValid(colorValid)
);

// ---- sim/ddpl_host_model.sv ----
// Host bus master that programs the palette registers
`timescale 1ns/1ps
module ddpl_host_model
  import ddpl_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Master outputs
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Idle bus at time zero
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One single word transfer, address phase held until hready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};  // Component in the upper nibble
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
endmodule : ddpl_host_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the dual palette lookup
`timescale 1ns/1ps
module tb_top
  import ddpl_pkg::*;
;
  // Bench signals
  logic        clk, reset, hsel, hwrite, hreadyout, hresp;
  logic        pixelValid, pixelReady, colorValid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rd;
  logic [15:0] pixelIn;
  logic [31:0] haddr, hwdata, hrdata, seed;
  ddpl_rgb_t   panelColor, crtColor, palP [256], palC [256], expP [$], expC [$];
  int          error_cnt, compares;

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Block and host
  ddpl_palette_lut ddpl_palette_lut_inst (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pixelIn(pixelIn),
    .pixelValid(pixelValid), .pixelReady(pixelReady), .panelColor(panelColor),
    .crtColor(crtColor), .colorValid(colorValid)
  );
  ddpl_host_model ddpl_host_model_inst (
    .clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic ddpl_rgb_t mono(input ddpl_rgb_t v, input logic col);
    return col ? v : {v.green, v.green, v.green};
  endfunction : mono
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    ddpl_host_model_inst.bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    ddpl_host_model_inst.bus(1'b0, a, 8'h00, rd);
    chk({24'h000000, rd}, {24'h000000, e});
  endtask : rdc
  // Load one entry with random components through the given access mode
  task automatic load(input logic [1:0] m, input logic [7:0] i);
    ddpl_rgb_t v;
    seed = lfsr(seed);
    v = seed[11:0];
    wr(ADDR_MODE, {6'h00, m});
    wr(ADDR_INDEX, i);
    wr(ADDR_DATA, {v.red, 4'h0});
    wr(ADDR_DATA, {v.green, 4'h0});
    wr(ADDR_DATA, {v.blue, 4'h0});
    if (m != 2'h2) palP[i] = v;
    if (m != 2'h1) palC[i] = v;
  endtask : load
  // Read one entry back and the stepped index
  task automatic readback(input logic [1:0] m, input logic [7:0] i);
    ddpl_rgb_t v;
    v = m[1] ? palC[i] : palP[i];
    wr(ADDR_MODE, {6'h00, m});
    wr(ADDR_INDEX, i);
    rdc(ADDR_DATA, {v.red, 4'h0});
    rdc(ADDR_DATA, {v.green, 4'h0});
    rdc(ADDR_DATA, {v.blue, 4'h0});
    rdc(ADDR_INDEX, i + 8'h01);
  endtask : readback
  task automatic note(input ddpl_rgb_t p, input ddpl_rgb_t c, input logic col);
    expP.push_back(mono(p, col));
    expC.push_back(c);
  endtask : note
  // Offer one pixel word and note what must come out
  task automatic pix(input logic [1:0] d, input logic [15:0] v, input logic col);
    ddpl_rgb_t x;
    x = (d == 2'h2) ? {v[14:11], v[9:6], v[4:1]} : {v[15:12], v[10:7], v[4:1]};
    if (d[1]) note(x, x, col);
    else if (d[0]) note(palP[v[7:0]], palC[v[7:0]], col);
    else begin
      note(palP[v[7:4]], palC[v[7:4]], col);
      note(palP[v[3:0]], palC[v[3:0]], col);
    end
    pixelIn    <= v;
    pixelValid <= 1'b1;
    do @(posedge clk); while (pixelReady !== 1'b1);
  endtask : pix
  task automatic idle();
    pixelValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idle
  task automatic close_out();
    chk(expP.size(), 32'h0);
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  // Compare each output pixel with the oldest note
  always @(negedge clk) begin
    if (colorValid === 1'b1 && expP.size() > 0) begin
      chk({20'h00000, panelColor}, {20'h00000, expP.pop_front()});
      chk({20'h00000, crtColor}, {20'h00000, expC.pop_front()});
    end else if (colorValid === 1'b1) begin
      chk(32'h1, 32'h0);
    end
  end

  // Watchdog
  initial begin
    #400us;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial begin
    seed = 32'h0000B7F6;
    error_cnt = 0;
    compares = 0;
    reset = 1'b1;
    pixelIn = 16'h0000;
    pixelValid = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(ADDR_MODE, 8'h00);
    rdc(ADDR_INDEX, 8'h00);
    rdc(ADDR_PANEL_CFG, 8'h00);
    rdc(ADDR_DEPTH, 8'h01);
    rdc(12'hFFC, 8'h00);
    $display("test 1 done");
    for (int i = 0; i < 256; i++) load(2'h0, i[7:0]);
    load(2'h1, 8'h10);
    load(2'h2, 8'h10);
    wr(ADDR_INDEX, 8'h10);
    rdc(ADDR_DATA, {palC[16].red, 4'h0});
    for (int m = 0; m < 4; m++) readback(m[1:0], 8'h10);
    readback(2'h0, 8'hFF);
    $display("test 2 done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PANEL_CFG, {5'h00, k[2], 2'h0});
      wr(ADDR_DEPTH, {6'h00, k[1:0]});
      for (int n = 0; n < 3; n++) begin
        seed = lfsr(seed);
        pix(k[1:0], seed[15:0], k[2]);
      end
      pix(k[1:0], 16'h0010, k[2]);
      idle();
    end
    $display("test 3 done");
    close_out();
  end
endmodule : tb_top
